/* File: rtl/sbpa_defs.svh */
// Constants for the shared bus memory port
`ifndef SBPA_DEFS_SVH
`define SBPA_DEFS_SVH
`define SBPA_STAT_W 4
`define SBPA_ADDR_W 32
`define SBPA_DATA_W 32
`define SBPA_CTRL_W 4
`define SBPA_STAT_IDLE 4'h_F
`define SBPA_STAT_DMA_READ 4'h_1
`define SBPA_STAT_STROBE_ONE_WRITE 4'h_2
`define SBPA_STAT_LOCK_PEND 4'h_3
`define SBPA_STAT_CPU_READ 4'h_4
`define SBPA_STAT_CPU_WRITE 4'h_5
`define SBPA_STAT_DMA_WRITE 4'h_6
`define SBPA_CTRL_IDLE 4'h_F
`endif

/* File: rtl/sbpa_pkg.sv */
// Types for the shared bus memory port
`default_nettype none
package sbpa_pkg;
    typedef enum logic [1:0] {
        SBPA_IDLE,
        SBPA_ADDR,
        SBPA_WAIT
    } sbpa_state_e;
endpackage
`default_nettype wire

/* File: rtl/sbpa_sync.sv */
// Two-flop synchroniser for a vector of pin inputs
`default_nettype none
module sbpa_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sbpa_sync
`default_nettype wire

/* File: rtl/sbpa_port.sv */
// Shared-bus memory port: status code, access sequencing and drive enables
`default_nettype none
`include "sbpa_defs.svh"
// Operation
// [RULE1] Port drives a four-bit status code naming the access now starting.
// [RULE2] Outside logic decodes status into single or locked bus requests.
// [RULE3] Each high drive-enable input floats control, address or data lines.
// [RULE4] Drive enables act at once, combinationally, without the clock.
// [RULE5] Floating the port never suspends the access in progress.
// [RULE6] Outside logic stretches shared accesses with wait states via ready.
// [RULE7] Ready comes only after the port regains the bus and has time.
// [RULE8] Arbiter lets at most one processor drive the shared bus.
// [RULE9] Arbiter gives every processor a fair chance at the bus.
// [RULE10] Above 32 MHz, no revoking mastership between same-page reads.
// [RULE11] Shared memory selects stay high while no processor holds a grant.
// [RULE12] Locked request keeps the master until status leaves locked pending.
module sbpa_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_dma,
    input wire logic req_lock,
    input wire logic req_strobe_one,
    input wire logic [`SBPA_ADDR_W-1:0] req_addr,
    input wire logic [`SBPA_DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [`SBPA_DATA_W-1:0] rsp_rdata,
    input wire logic control_drive_enable_n,
    input wire logic address_drive_enable_n,
    input wire logic data_drive_enable_n,
    input wire logic access_ready_n,
    output logic [`SBPA_STAT_W-1:0] access_status_code,
    output logic [`SBPA_CTRL_W-1:0] ctrl_o,
    output logic ctrl_oe,
    output logic [`SBPA_ADDR_W-1:0] addr_o,
    output logic addr_oe,
    output logic [`SBPA_DATA_W-1:0] data_o,
    output logic data_oe,
    input wire logic [`SBPA_DATA_W-1:0] data_i
);
    sbpa_pkg::sbpa_state_e state;
    sbpa_pkg::sbpa_state_e next_state;
    logic ready_s;
    logic [`SBPA_DATA_W-1:0] data_s;
    logic cur_write;
    logic cur_lock;
    logic [`SBPA_STAT_W-1:0] next_status;
    logic [`SBPA_CTRL_W-1:0] ctrl_q;
    logic [`SBPA_ADDR_W-1:0] addr_q;
    logic [`SBPA_DATA_W-1:0] wdata_q;
    logic drive_q;
    logic wr_drive_q;

    // Ready pin is asynchronous to this clock
    sbpa_sync #(.W(1), .INIT(1'b1)) u_rdy_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(access_ready_n),
        .q(ready_s)
    );
    sbpa_sync #(.W(`SBPA_DATA_W), .INIT('0)) u_dat_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(data_i),
        .q(data_s)
    );

    wire take_req = (state == sbpa_pkg::SBPA_IDLE) && req_valid;
    // Sequence runs on, bus released or not; only ready ends it
    wire access_done = (state == sbpa_pkg::SBPA_WAIT) && !ready_s; // see [RULE5]

    // Status code for the access beginning this cycle
    always_comb begin
        next_status = `SBPA_STAT_IDLE;
        if (take_req) begin
            if (req_lock)
                next_status = `SBPA_STAT_LOCK_PEND;
            else if (req_dma && !req_write)
                next_status = `SBPA_STAT_DMA_READ;
            else if (req_dma)
                next_status = `SBPA_STAT_DMA_WRITE;
            else if (req_strobe_one && req_write)
                next_status = `SBPA_STAT_STROBE_ONE_WRITE;
            else if (req_write)
                next_status = `SBPA_STAT_CPU_WRITE;
            else
                next_status = `SBPA_STAT_CPU_READ;
        end else if (state != sbpa_pkg::SBPA_IDLE && !access_done && cur_lock) begin
            next_status = `SBPA_STAT_LOCK_PEND; // see [RULE12]
        end else if (state != sbpa_pkg::SBPA_IDLE && !access_done) begin
            // Code stands for the whole access
            next_status = access_status_code; // see [RULE1]
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            sbpa_pkg::SBPA_IDLE: begin
                if (req_valid)
                    next_state = sbpa_pkg::SBPA_ADDR;
            end
            sbpa_pkg::SBPA_ADDR: begin
                next_state = sbpa_pkg::SBPA_WAIT;
            end
            sbpa_pkg::SBPA_WAIT: begin
                if (!ready_s)
                    next_state = sbpa_pkg::SBPA_IDLE; // see [RULE6]
            end
            default: begin
                next_state = sbpa_pkg::SBPA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= sbpa_pkg::SBPA_IDLE;
            access_status_code <= `SBPA_STAT_IDLE;
            cur_write <= 1'b0;
            cur_lock <= 1'b0;
        end else begin
            state <= next_state;
            access_status_code <= next_status; // see [RULE1]
            if (take_req) begin
                cur_write <= req_write;
                cur_lock <= req_lock;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= `SBPA_CTRL_IDLE;
            addr_q <= '0;
            wdata_q <= '0;
            drive_q <= 1'b0;
            wr_drive_q <= 1'b0;
        end else begin
            if (take_req) begin
                addr_q <= req_addr;
                wdata_q <= req_wdata;
                ctrl_q <= {~req_write, req_write, ~req_strobe_one, req_strobe_one};
            end else if (access_done) begin
                ctrl_q <= `SBPA_CTRL_IDLE;
            end
            drive_q <= take_req || (state != sbpa_pkg::SBPA_IDLE && !access_done);
            wr_drive_q <= (take_req && req_write)
                || (state != sbpa_pkg::SBPA_IDLE && !access_done && cur_write);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            req_ready <= (next_state == sbpa_pkg::SBPA_IDLE);
            rsp_valid <= access_done;
            if (access_done && !cur_write)
                rsp_rdata <= data_s;
        end
    end

    // Drivers gated straight by the pins, no clock in the path
    assign ctrl_o = ctrl_q;
    assign addr_o = addr_q;
    assign data_o = wdata_q;
    assign ctrl_oe = drive_q && !control_drive_enable_n; // see [RULE3] see [RULE4]
    assign addr_oe = drive_q && !address_drive_enable_n; // see [RULE3] see [RULE4]
    assign data_oe = wr_drive_q && !data_drive_enable_n; // see [RULE3] see [RULE4]
endmodule // sbpa_port
`default_nettype wire

/* File: bench/sbpa_port_assertions.sv */
// Port checks for the shared bus memory port
`default_nettype none
`include "sbpa_defs.svh"
module sbpa_port_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [3:0] access_status_code,
    input wire logic ctrl_oe,
    input wire logic addr_oe,
    input wire logic data_oe,
    input wire logic control_drive_enable_n,
    input wire logic address_drive_enable_n,
    input wire logic data_drive_enable_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_take; req_valid && req_ready; endsequence
    sequence s_busy; access_status_code != `SBPA_STAT_IDLE; endsequence
    property p_code; s_take |=> s_busy ##1 $stable(access_status_code); endproperty
    a_code: assert property (p_code) else $error("no status after take");
    property p_done; rsp_valid |-> access_status_code == `SBPA_STAT_IDLE && !ctrl_oe; endproperty
    a_done: assert property (p_done) else $error("status not idle at end");
    property p_ce; control_drive_enable_n |-> !ctrl_oe; endproperty
    a_ce: assert property (p_ce) else $error("control driven while floated");
    property p_ae; address_drive_enable_n |-> !addr_oe; endproperty
    a_ae: assert property (p_ae) else $error("address driven while floated");
    property p_de; data_drive_enable_n |-> !data_oe; endproperty
    a_de: assert property (p_de) else $error("data driven while floated");
    property p_float;
        s_busy and (control_drive_enable_n || address_drive_enable_n)
            |=> $stable(access_status_code);
    endproperty
    a_float: assert property (p_float) else $error("access dropped while floated");
endmodule // sbpa_port_assertions
bind sbpa_port sbpa_port_assertions chk_u (.*);
`default_nettype wire

/* File: bench/sbpa_arbiter_model.sv */
// Arbiter and shared memory standing beyond the port
`default_nettype none
`include "sbpa_defs.svh"
module sbpa_arbiter_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] hold,
    input wire logic [2:0] wait_cyc,
    input wire logic [3:0] access_status_code,
    input wire logic [31:0] addr_o,
    output logic control_drive_enable_n,
    output logic address_drive_enable_n,
    output logic data_drive_enable_n,
    output logic access_ready_n,
    output logic [31:0] data_i
);
    logic [3:0] cnt;
    assign {control_drive_enable_n, address_drive_enable_n, data_drive_enable_n} = hold;
    // Ready only once the bus is back and the wait spent; gone when the port idles
    assign access_ready_n = !(access_status_code != `SBPA_STAT_IDLE && hold == 3'b000
        && cnt > {1'b0, wait_cyc});
    assign data_i = ~addr_o;
    always_ff @(posedge clk_sys) begin
        if (rst || access_status_code == `SBPA_STAT_IDLE) cnt <= 4'h_0;
        else if (hold == 3'b000 && cnt != 4'h_F) cnt <= cnt + 4'h_1;
    end
endmodule // sbpa_arbiter_model
`default_nettype wire

/* File: bench/test_shared_bus_port_arbitration.sv */
// Random and corner accesses through the shared bus memory port
`default_nettype none
`include "sbpa_defs.svh"
module test_shared_bus_port_arbitration;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, req_valid = 0, req_write = 0, req_dma = 0, req_lock = 0;
    logic req_strobe_one = 0, req_ready, rsp_valid, ctrl_oe, addr_oe, data_oe, access_ready_n;
    logic control_drive_enable_n, address_drive_enable_n, data_drive_enable_n;
    logic [31:0] req_addr = 0, req_wdata = 0, rsp_rdata, addr_o, data_o, data_i;
    logic [3:0] access_status_code, ctrl_o;
    logic [2:0] hold = 0, wait_cyc = 0;
    logic [31:0] rng = 32'h_0000_0053;
    int miscompares = 0, checks_done = 0;
    sbpa_port dut_u (.*);
    sbpa_arbiter_model arb_u (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic logic [3:0] exp_code(logic [31:0] r);
        if (r[5]) return `SBPA_STAT_LOCK_PEND;
        if (r[4]) return r[3] ? `SBPA_STAT_DMA_WRITE : `SBPA_STAT_DMA_READ;
        if (r[3]) return r[6] ? `SBPA_STAT_STROBE_ONE_WRITE : `SBPA_STAT_CPU_WRITE;
        return `SBPA_STAT_CPU_READ;
    endfunction
    task chk(logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Fields, float pattern and waits all drawn from one word
    task access(logic [31:0] r);
        while (req_ready !== 1'b1) @(negedge clk_sys);
        {req_strobe_one, req_lock, req_dma, req_write} = r[6:3];
        {req_addr, req_wdata, wait_cyc, req_valid} = {r, ~r, r[16:14], 1'b1};
        @(negedge clk_sys);
        req_valid = 0;
        chk(access_status_code, exp_code(r));
        // A float spell always floats something, so the access cannot end inside it
        hold = (r[13:11] != 3'b000 && r[10:8] == 3'b000) ? 3'b100 : r[10:8];
        #1 chk({ctrl_oe, addr_oe, data_oe} & hold, 0);
        repeat (r[13:11]) @(negedge clk_sys);
        hold = 0;
        #1 chk({ctrl_oe, addr_oe}, 2'b11);
        while (rsp_valid !== 1'b1) @(negedge clk_sys);
        if (!r[3]) chk(rsp_rdata, ~r);
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 0;
        access(32'h_0000_0000);
        access(32'h_FFFF_FFFF);
        repeat (60) begin
            rng = xs(rng);
            access(rng);
        end
        final_report;
    end
    initial begin
        #20000;
        miscompares++;
        final_report;
    end
endmodule // test_shared_bus_port_arbitration
`default_nettype wire
